// >>> logic/playout_defines.svh
// Register offsets, field positions, reset values and constants of the playout block
`ifndef PLAYOUT_DEFINES_SVH
`define PLAYOUT_DEFINES_SVH

`define CHANNELS 32
`define PORT_INDEX 20'h00000
`define CTRL_STRUCT_BASE 20'hA0000
`define CTRL_STRUCT_STRIDE 20'h00800
`define CTRL_STRUCT_SPAN 20'h00080
`define REG_CTRL3 20'h00000
`define REG_MAIN_CTRL1 20'h00004
`define REG_CTRL4 20'h00008
`define REG_CTRL5 20'h0000C
`define REG_CTRL6 20'h00010
`define CTRL3_REPLAY_BIT 10
`define CTRL3_BASE_LSB 0
`define MAIN1_SILENCE_LSB 8
`define CTRL3_RESET 16'h0000
`define MAIN1_RESET 16'hFF00
`define ENTRY_RESET 16'h0001
`define ADDR_SHIFT_ZEROS 5'h1F
`define LAST_CHANNEL 5'h1F
`define NEIGHBOUR_GAP 6'h04

`endif

// >>> logic/playout_pkg.sv
// Types shared by the playout block and its submodules
package playout_pkg;
	// Per-channel control entry
	typedef struct packed {
		logic valid;
		logic simple_underrun_report_enable;
		logic idle;
		logic permanent_underrun_report_enable;
		logic [1:0] spare;
		logic [9:0] buf_addr;
	} ctrl_entry_s;

	// Circular buffer entry as written by the cell_reassembler
	typedef struct packed {
		logic mf;
		logic res;
		logic [1:0] turn;
		logic [3:0] cas;
		logic [7:0] data;
	} buf_entry_s;

	typedef enum logic [1:0] {UR_NONE, UR_SIMPLE, UR_PERM} underrun_e;

	typedef enum logic [1:0] {S_IDLE, S_ENTRY, S_READ, S_NEXT} sweep_e;
endpackage

// >>> logic/underrun_judge.sv
// Classifies a channel read as no, simple or permanent underrun
`timescale 1ns/1ns
`default_nettype none
module underrun_judge
	import playout_pkg::*;
(
	input wire logic [1:0] rp_turn,
	input wire logic [1:0] entry_turn,
	input wire logic neighbour_active,
	output underrun_e kind
);
	logic [1:0] diff;

	// Distance of the read pointer ahead of the stored turn
	assign diff = rp_turn - entry_turn;

	// Compare pointer top bits with stored turn
	always_comb
	begin
		if (diff == 2'h3)
			kind = UR_PERM;
		else if (diff != 2'h0)
			kind = UR_SIMPLE;
		else if (!neighbour_active)
			kind = UR_SIMPLE;
		else
			kind = UR_NONE;
	end
endmodule
`default_nettype wire

// >>> logic/tdm_serializer.sv
// Shifts the per-port output buffer out serially, one timeslot per channel
`timescale 1ns/1ns
`default_nettype none
module tdm_serializer
	import playout_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic frame_tick,
	input wire logic bit_tick,
	input wire logic [255:0] out_bytes,
	input wire logic [31:0] out_valid,
	output logic tdm_serial_data_out,
	output logic tdm_serial_data_oe
);
	logic [7:0] bit_cnt_reg;
	logic [7:0] bit_cnt_next;
	logic data_reg;
	logic data_next;
	logic oe_reg;
	logic oe_next;
	logic [4:0] chan;
	logic [2:0] bitpos;

	assign chan = bit_cnt_reg[7:3];
	assign bitpos = 3'h7 - bit_cnt_reg[2:0];

	// Bit position in the frame and next line value
	always_comb
	begin
		bit_cnt_next = bit_cnt_reg;
		data_next = data_reg;
		oe_next = oe_reg;
		if (frame_tick)
			bit_cnt_next = 8'h00;
		else if (bit_tick)
		begin
			data_next = out_bytes[{chan, bitpos}];
			oe_next = out_valid[chan];
			bit_cnt_next = bit_cnt_reg + 8'h01;
		end
	end

	// Register the line state
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bit_cnt_reg <= 8'h00;
			data_reg <= 1'b0;
			oe_reg <= 1'b0;
		end
		else
		begin
			bit_cnt_reg <= bit_cnt_next;
			data_reg <= data_next;
			oe_reg <= oe_next;
		end
	end

	assign tdm_serial_data_out = data_reg;
	assign tdm_serial_data_oe = oe_reg;
endmodule
`default_nettype wire

// >>> logic/reassembly_playout.sv
// Structured TDM reassembly playout with underrun detection and register slave
`include "playout_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module reassembly_playout
	import playout_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [19:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [22:0] mem_address,
	output logic mem_read,
	input wire logic [15:0] mem_readdata,
	input wire logic mem_waitrequest,
	input wire logic frame_tick,
	input wire logic bit_tick,
	output logic tdm_serial_data_out,
	output logic tdm_serial_data_oe,
	output logic sweep_busy
);
	// Low bits up to and including the size marker of a buffer address field
	function automatic logic [4:0] size_low_mask(input logic [9:0] a);
		logic [4:0] m;
		m = 5'h01;
		if (a[0])
			m = 5'h01;
		else if (a[1])
			m = 5'h03;
		else if (a[2])
			m = 5'h07;
		else if (a[3])
			m = 5'h0F;
		else if (a[4])
			m = 5'h1F;
		return m;
	endfunction

	// Entry count minus one for the coded buffer size
	function automatic logic [9:0] wrap_mask(input logic [9:0] a);
		return {size_low_mask(a), `ADDR_SHIFT_ZEROS};
	endfunction

	// Offset of the buffer start: entry bits 9:k+1 then k+6 zeros, k the size marker bit
	function automatic logic [14:0] buf_offset(input logic [9:0] a);
		logic [9:0] keep;
		keep = a & ~{5'h00, size_low_mask(a)};
		return {keep, 5'h00};
	endfunction

	// Byte write merge for 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0])
			r[7:0] = wd[7:0];
		if (be[1])
			r[15:8] = wd[15:8];
		return r;
	endfunction

	// Software-visible state
	logic [15:0] ctrl3_reg, ctrl3_next;
	logic [15:0] main1_reg, main1_next;
	logic [31:0] underrun_status_reg, underrun_status_next;
	logic [31:0] perm_status_reg, perm_status_next;
	ctrl_entry_s entry_reg [0:31];
	ctrl_entry_s entry_next [0:31];
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;

	// Playout state
	sweep_e state_reg, state_next;
	logic [4:0] ch_reg, ch_next;
	logic [9:0] rp_idx_reg [0:31];
	logic [9:0] rp_idx_next [0:31];
	logic [1:0] rp_turn_reg [0:31];
	logic [1:0] rp_turn_next [0:31];
	logic [7:0] out_byte_reg [0:31];
	logic [7:0] out_byte_next [0:31];
	logic [31:0] out_valid_reg, out_valid_next;
	logic [22:0] mem_addr_reg, mem_addr_next;

	logic [19:0] cs_base;
	logic [19:0] cs_rel;
	logic in_cs;
	logic [4:0] cs_idx;
	logic bus_req;
	ctrl_entry_s cur;
	buf_entry_s rd_entry;
	logic [5:0] nb_idx;
	logic nb_active;
	underrun_e kind;
	logic replay;
	logic [7:0] silence;
	logic [255:0] out_flat;

	assign replay = ctrl3_reg[`CTRL3_REPLAY_BIT];
	assign silence = main1_reg[`MAIN1_SILENCE_LSB +: 8];
	assign cur = entry_reg[ch_reg];
	assign rd_entry = mem_readdata;
	assign nb_idx = {1'b0, ch_reg} + `NEIGHBOUR_GAP;
	assign nb_active = nb_idx[5] | entry_reg[nb_idx[4:0]].valid;

	// Control structure window for this port
	assign cs_base = `CTRL_STRUCT_BASE + `PORT_INDEX * `CTRL_STRUCT_STRIDE;
	assign cs_rel = avs_address - cs_base;
	assign in_cs = (avs_address >= cs_base) && (cs_rel < `CTRL_STRUCT_SPAN);
	assign cs_idx = cs_rel[6:2];
	assign bus_req = (avs_read | avs_write) & ~ack_reg;

	// Classify the fetched buffer entry
	underrun_judge judge_i (
		.rp_turn(rp_turn_reg[ch_reg]),
		.entry_turn(rd_entry.turn),
		.neighbour_active(nb_active),
		.kind(kind)
	);

	// Register file, status flags and playout sweep
	always_comb
	begin
		ctrl3_next = ctrl3_reg;
		main1_next = main1_reg;
		underrun_status_next = underrun_status_reg;
		perm_status_next = perm_status_reg;
		entry_next = entry_reg;
		ack_next = bus_req;
		rdata_next = rdata_reg;
		state_next = state_reg;
		ch_next = ch_reg;
		rp_idx_next = rp_idx_reg;
		rp_turn_next = rp_turn_reg;
		out_byte_next = out_byte_reg;
		out_valid_next = out_valid_reg;
		mem_addr_next = mem_addr_reg;
		// Bus write, taken at the edge where waitrequest is low
		if (ack_reg && avs_write)
		begin
			if (in_cs)
				entry_next[cs_idx] = merge16(entry_reg[cs_idx], avs_writedata, avs_byteenable);
			else if (avs_address == `REG_CTRL3)
				ctrl3_next = merge16(ctrl3_reg, avs_writedata, avs_byteenable);
			else if (avs_address == `REG_MAIN_CTRL1)
				main1_next = merge16(main1_reg, avs_writedata, avs_byteenable);
			else if (avs_address == `REG_CTRL4)
				underrun_status_next = underrun_status_reg & ~avs_writedata;
			else if (avs_address == `REG_CTRL5)
				perm_status_next[15:0] = perm_status_reg[15:0] & ~avs_writedata[15:0];
			else if (avs_address == `REG_CTRL6)
				perm_status_next[31:16] = perm_status_reg[31:16] & ~avs_writedata[15:0];
		end
		// Bus read data, unmapped reads as zero
		if (bus_req && avs_read)
		begin
			if (in_cs)
				rdata_next = {16'h0000, entry_reg[cs_idx]};
			else if (avs_address == `REG_CTRL3)
				rdata_next = {16'h0000, ctrl3_reg};
			else if (avs_address == `REG_MAIN_CTRL1)
				rdata_next = {16'h0000, main1_reg};
			else if (avs_address == `REG_CTRL4)
				rdata_next = underrun_status_reg;
			else if (avs_address == `REG_CTRL5)
				rdata_next = {16'h0000, perm_status_reg[15:0]};
			else if (avs_address == `REG_CTRL6)
				rdata_next = {16'h0000, perm_status_reg[31:16]};
			else
				rdata_next = 32'h00000000;
		end
		// Channel sweep, once per frame
		case (state_reg)
			S_IDLE:
			begin
				if (frame_tick)
				begin
					ch_next = 5'h00;
					state_next = S_ENTRY;
				end
			end
			S_ENTRY:
			begin
				if (cur.valid)
				begin
					mem_addr_next = {ctrl3_reg[`CTRL3_BASE_LSB +: 8],
						buf_offset(cur.buf_addr) | {5'h00, rp_idx_reg[ch_reg]}};
					state_next = S_READ;
				end
				else
				begin
					out_valid_next[ch_reg] = 1'b0;
					state_next = S_NEXT;
				end
			end
			S_READ:
			begin
				if (!mem_waitrequest)
				begin
					out_valid_next[ch_reg] = 1'b1;
					// Replay keeps the old buffer byte, otherwise silence
					if ((kind != UR_NONE || perm_status_reg[ch_reg]) && !replay)
						out_byte_next[ch_reg] = silence;
					else
						out_byte_next[ch_reg] = rd_entry.data;
					// Reports; a hardware set wins over a software clear
					if (kind == UR_SIMPLE && cur.simple_underrun_report_enable)
						underrun_status_next[ch_reg] = 1'b1;
					if (kind == UR_PERM && cur.permanent_underrun_report_enable)
					begin
						underrun_status_next[ch_reg] = 1'b1;
						perm_status_next[ch_reg] = 1'b1;
					end
					// Advance pointer, wrapping at the coded size
					if (rp_idx_reg[ch_reg] == wrap_mask(cur.buf_addr))
					begin
						rp_idx_next[ch_reg] = 10'h000;
						rp_turn_next[ch_reg] = rp_turn_reg[ch_reg] + 2'h1;
					end
					else
						rp_idx_next[ch_reg] = (rp_idx_reg[ch_reg] + 10'h001) & wrap_mask(cur.buf_addr);
					state_next = S_NEXT;
				end
			end
			S_NEXT:
			begin
				if (ch_reg == `LAST_CHANNEL)
					state_next = S_IDLE;
				else
				begin
					ch_next = ch_reg + 5'h01;
					state_next = S_ENTRY;
				end
			end
			default:
				state_next = S_IDLE;
		endcase
	end

	// Register all state
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl3_reg <= `CTRL3_RESET;
			main1_reg <= `MAIN1_RESET;
			underrun_status_reg <= 32'h00000000;
			perm_status_reg <= 32'h00000000;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			state_reg <= S_IDLE;
			ch_reg <= 5'h00;
			out_valid_reg <= 32'h00000000;
			mem_addr_reg <= 23'h000000;
			for (int i = 0; i < `CHANNELS; i++)
			begin
				entry_reg[i] <= `ENTRY_RESET;
				rp_idx_reg[i] <= 10'h000;
				rp_turn_reg[i] <= 2'h0;
				out_byte_reg[i] <= 8'hFF;
			end
		end
		else
		begin
			ctrl3_reg <= ctrl3_next;
			main1_reg <= main1_next;
			underrun_status_reg <= underrun_status_next;
			perm_status_reg <= perm_status_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			state_reg <= state_next;
			ch_reg <= ch_next;
			out_valid_reg <= out_valid_next;
			mem_addr_reg <= mem_addr_next;
			entry_reg <= entry_next;
			rp_idx_reg <= rp_idx_next;
			rp_turn_reg <= rp_turn_next;
			out_byte_reg <= out_byte_next;
		end
	end

	// Flatten output buffer for the serializer
	always_comb
	begin
		out_flat = 256'h0;
		for (int i = 0; i < `CHANNELS; i++)
			out_flat[i*8 +: 8] = out_byte_reg[i];
	end

	tdm_serializer ser_i (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.frame_tick(frame_tick),
		.bit_tick(bit_tick),
		.out_bytes(out_flat),
		.out_valid(out_valid_reg),
		.tdm_serial_data_out(tdm_serial_data_out),
		.tdm_serial_data_oe(tdm_serial_data_oe)
	);

	// Bus handshake and memory request
	assign avs_waitrequest = bus_req;
	assign avs_readdata = rdata_reg;
	assign mem_read = (state_reg == S_READ);
	assign mem_address = mem_addr_reg;
	assign sweep_busy = (state_reg != S_IDLE);
endmodule
`default_nettype wire

// >>> testbench/playout_checker.sv
// Port assertions of the playout block
`include "playout_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module playout_checker
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [19:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [22:0] mem_address,
	input wire logic mem_read,
	input wire logic mem_waitrequest,
	input wire logic frame_tick,
	input wire logic bit_tick,
	input wire logic tdm_serial_data_out,
	input wire logic tdm_serial_data_oe,
	input wire logic sweep_busy
);
	logic [7:0] base_reg;
	logic [7:0] base_next;
	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;

	// Shadow of the base field and count of buffer reads per frame
	always_comb
	begin
		base_next = base_reg;
		if (avs_write && !avs_waitrequest && avs_address == `REG_CTRL3 && avs_byteenable[0])
			base_next = avs_writedata[7:0];
		cnt_next = frame_tick ? 6'h00 : cnt_reg + {5'h00, mem_read && !mem_waitrequest};
	end

	// Registers the shadow state
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			base_reg <= 8'h00;
			cnt_reg <= 6'h00;
		end
		else
		begin
			base_reg <= base_next;
			cnt_reg <= cnt_next;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// Slave stalls one cycle, then answers
	sequence bus_walk;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence

	bus_answer_a: assert property ($rose(avs_read || avs_write) |-> bus_walk)
		else $error("bus answer not one cycle late");
	bus_idle_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("stall without request");
	rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data moved without a read");
	base_field_a: assert property (mem_read |-> mem_address[22:15] == base_reg)
		else $error("buffer address lacks base field");
	mem_hold_a: assert property (mem_read && mem_waitrequest |=> mem_read && $stable(mem_address))
		else $error("buffer read dropped while stalled");
	mem_end_a: assert property ($fell(mem_read) |-> !$past(mem_waitrequest))
		else $error("buffer read ended without answer");
	sweep_start_a: assert property (frame_tick && !sweep_busy |=> sweep_busy)
		else $error("frame did not start sweep");
	sweep_only_a: assert property (!sweep_busy |-> !mem_read)
		else $error("buffer read outside sweep");
	frame_reads_a: assert property (cnt_reg <= 6'h20)
		else $error("more than one read per channel");
	serial_step_a: assert property ($changed(tdm_serial_data_out) || $changed(tdm_serial_data_oe)
		|-> $past(bit_tick))
		else $error("serial line moved off bit tick");
endmodule

bind reassembly_playout playout_checker i_playout_checker (.clk_sys(clk_sys), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.mem_address(mem_address), .mem_read(mem_read), .mem_waitrequest(mem_waitrequest),
	.frame_tick(frame_tick), .bit_tick(bit_tick), .tdm_serial_data_out(tdm_serial_data_out),
	.tdm_serial_data_oe(tdm_serial_data_oe), .sweep_busy(sweep_busy));
`default_nettype wire

// >>> testbench/buffer_memory_model.sv
// External circular buffer memory with random stalls
`timescale 1ns/1ns
`default_nettype none
module buffer_memory_model
	import playout_pkg::*;
(
	input wire logic clk_sys,
	input wire logic mem_read,
	input wire logic [1:0] turn_val,
	input wire logic [7:0] byte_val,
	output logic [15:0] mem_readdata,
	output var logic mem_waitrequest = 1'b1
);
	int seed = 2;
	int r;
	logic tog = 1'b0;
	buf_entry_s ent;

	// Entry as the writer left it, turn from its pointer
	assign ent = '{mf: 1'b0, res: 1'b0, turn: turn_val, cas: 4'h0, data: byte_val};
	// Answered word, or a toggling bus while stalled
	assign mem_readdata = mem_waitrequest ? {16{tog}} : ent;

	// Random stall on each request cycle
	always @(posedge clk_sys)
	begin
		r = $random(seed);
		mem_waitrequest <= !mem_read || r[0];
		tog <= !tog;
	end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench of the playout block
`include "playout_defines.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("Error %0t: %h not %h", $time, g, e); end end
module testbench
	import playout_pkg::*;
;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [19:0] avs_address = 20'h00000;
	logic avs_read = 1'b0, avs_write = 1'b0, frame_tick = 1'b0, bit_tick = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
	logic [3:0] avs_byteenable = 4'h3;
	logic avs_waitrequest, mem_read, mem_waitrequest, tdm_serial_data_out, tdm_serial_data_oe, sweep_busy;
	logic [22:0] mem_address, m_a, exp_a;
	logic [15:0] mem_readdata, b, o;
	logic [1:0] turn_val = 2'h0;
	logic [7:0] byte_val = 8'h00, exp_b;
	logic [31:0] exp_q[$];
	logic [31:0] exp_r;
	int err_total = 0, n_compared = 0, seed = 2, nf = 0;
	// Cases: replay, turn, silent, ctrl4, ctrl5, clear
	logic [6:0] tab [7] = '{7'h01, 7'h3D, 7'h65, 7'h1E, 7'h0F, 7'h01, 7'h57};

	reassembly_playout i_reassembly_playout (.clk_sys(clk_sys), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.mem_address(mem_address), .mem_read(mem_read), .mem_readdata(mem_readdata),
		.mem_waitrequest(mem_waitrequest), .frame_tick(frame_tick), .bit_tick(bit_tick),
		.tdm_serial_data_out(tdm_serial_data_out), .tdm_serial_data_oe(tdm_serial_data_oe),
		.sweep_busy(sweep_busy));
	buffer_memory_model i_buffer_memory_model (.clk_sys(clk_sys), .mem_read(mem_read),
		.turn_val(turn_val), .byte_val(byte_val), .mem_readdata(mem_readdata),
		.mem_waitrequest(mem_waitrequest));

	// 50 MHz clock
	always #10 clk_sys = ~clk_sys;

	// Compares each read answer with the oldest expectation
	always @(posedge clk_sys)
		if (avs_read && !avs_waitrequest)
		begin
			exp_r = exp_q.pop_front();
			`CHK(avs_readdata, exp_r)
		end

	// Prints counts and verdict, then ends the run
	task automatic stop_test;
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One bus transfer, held until the slave answers
	task automatic bus(input logic wr, input logic [19:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
			@(posedge clk_sys);
		while (avs_waitrequest);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Read with the answer noted for the monitor
	task automatic rd(input logic [19:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		bus(1'b0, a, 32'h00000000);
	endtask

	// One frame: sweep, then shift out channels 0 and 1
	task automatic play;
		frame_tick <= 1'b1;
		@(posedge clk_sys);
		frame_tick <= 1'b0;
		m_a = 23'h000000;
		// Channel 0 is the first buffer read of each sweep
		do
		begin
			@(negedge clk_sys);
			if (mem_read && m_a == 23'h000000)
				m_a = mem_address;
		end
		while (sweep_busy);
		exp_a = {8'h3C, 9'h052, 6'(nf)};
		`CHK(m_a, exp_a)
		nf++;
		for (int j = 0; j < 16; j++)
		begin
			@(posedge clk_sys);
			bit_tick <= 1'b1;
			@(posedge clk_sys);
			bit_tick <= 1'b0;
			@(negedge clk_sys);
			b = {b[14:0], tdm_serial_data_out};
			o = {o[14:0], tdm_serial_data_oe};
		end
	endtask

	// Watchdog against a hang
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		err_total++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd(`REG_MAIN_CTRL1, 32'h0000FF00);
		rd(`REG_CTRL3, 32'h00000000);
		rd(20'h00100, 32'h00000000);
		rd(`REG_CTRL6, 32'h00000000);
		rd(`CTRL_STRUCT_BASE, 32'h00000001);
		bus(1'b1, `REG_MAIN_CTRL1, 32'h00005A00);
		bus(1'b1, `CTRL_STRUCT_BASE, 32'h0000D0A5);
		bus(1'b1, `CTRL_STRUCT_BASE + 20'h00010, 32'h000080C1);
		for (int i = 0; i < 7; i++)
		begin
			byte_val <= 8'($random(seed));
			turn_val <= tab[i][5:4];
			bus(1'b1, `REG_CTRL3, {21'h000000, tab[i][6], 10'h03C});
			play();
			exp_b = tab[i][3] ? 8'h5A : byte_val;
			`CHK(b[15:8], exp_b)
			`CHK(o, 16'hFF00)
			rd(`REG_CTRL4, {31'h00000000, tab[i][2]});
			rd(`REG_CTRL5, {31'h00000000, tab[i][1]});
			if (tab[i][0])
			begin
				bus(1'b1, `REG_CTRL4, 32'hFFFFFFFF);
				bus(1'b1, `REG_CTRL5, 32'h0000FFFF);
			end
			$display("case %0d done", i);
		end
		// Neighbour channel dropped: clean read of channel 0 misreports
		turn_val <= 2'h0;
		bus(1'b1, `REG_CTRL3, 32'h0000003C);
		bus(1'b1, `CTRL_STRUCT_BASE + 20'h00010, 32'h00000000);
		play();
		`CHK(b[15:8], 8'h5A)
		rd(`REG_CTRL4, 32'h00000001);
		$display("neighbour case done");
		stop_test();
	end
endmodule
`default_nettype wire
